// file: rtl/ohc_consts.vh
// Constants for the on/off hysteresis regulator
`ifndef OHC_CONSTS_VH
`define OHC_CONSTS_VH
`define OHC_NCH          4
`define OHC_VW           16
`define OHC_HYS_DEF      16'h000a
`define OHC_HYS_MIN      16'h0001
`define OHC_HYS_MAX      16'h270f
`define OHC_DB_DEF       16'h0000
`define OHC_DB_MIN       16'hf831
`define OHC_DB_MAX       16'h270f
`define OHC_ACT_DEF      1'b0
`define OHC_MODE_DEF     1'b1
`define OHC_PERIOD_NS    1000
`define OHC_CLK_NS       10
`define OHC_PERIOD_CYC   16'h0064
`endif

// file: rtl/ohc_channel.v
// One channel of on/off comparison with hysteresis and dead band
`timescale 1ns/1ps
module ohc_channel (
  input  wire               mclk,
  input  wire               reset,
  input  wire               tick,
  input  wire signed [15:0] pv,
  input  wire signed [15:0] sp,
  input  wire        [15:0] hys_heat,
  input  wire        [15:0] hys_cool,
  input  wire signed [15:0] dead_band,
  input  wire               action_direct,
  input  wire               heat_cool_type,
  output reg                heat_out_reg,
  output reg                cool_out_reg
);
  // Widened to 18 bits so no sum can wrap
  wire signed [17:0] pv_w  = {{2{pv[15]}}, pv};
  wire signed [17:0] sp_w  = {{2{sp[15]}}, sp};
  wire signed [17:0] hh_w  = {2'b00, hys_heat};
  wire signed [17:0] hc_w  = {2'b00, hys_cool};
  wire signed [17:0] db_w  = {{2{dead_band[15]}}, dead_band};
  // Heating side: off above heat_sp, back on below heat_sp - hys
  wire signed [17:0] heat_sp = heat_cool_type ? (sp_w - (db_w >>> 1)) : sp_w;
  wire signed [17:0] cool_sp = sp_w + (db_w >>> 1);
  wire heat_off = pv_w > heat_sp;
  wire heat_on  = pv_w < heat_sp - hh_w;
  // Cooling side mirrors heating about its own threshold
  wire cool_on  = pv_w > cool_sp;
  wire cool_off = pv_w < cool_sp - hc_w;
  reg heat_next;
  reg cool_next;
  reg fwd_next;

  // Single output: direct action swaps the sense, heat hysteresis kept
  always @* begin
    heat_next = heat_out_reg;
    cool_next = cool_out_reg;
    fwd_next  = heat_out_reg;
    if (heat_cool_type) begin
      // Dead band splits the thresholds so heating stays off inside it; cooling holds until hys_cool below cool_sp
      if (heat_off) heat_next = 1'b0;
      else if (heat_on) heat_next = 1'b1;
      if (cool_off) cool_next = 1'b0;
      else if (cool_on) cool_next = 1'b1;
    end else begin
      cool_next = 1'b0;
      if (!action_direct) begin
        if (heat_off) fwd_next = 1'b0;
        else if (heat_on) fwd_next = 1'b1;
      end else begin
        if (pv_w < sp_w) fwd_next = 1'b0;
        else if (pv_w > sp_w + hh_w) fwd_next = 1'b1;
      end
      heat_next = fwd_next;
    end
  end

  // Outputs clear on reset, otherwise move only on the control period tick
  always @(posedge mclk) begin
    if (reset) begin
      heat_out_reg <= 1'b0;
      cool_out_reg <= 1'b0;
    end else if (tick) begin
      heat_out_reg <= heat_next;
      cool_out_reg <= cool_next;
    end
  end
endmodule // ohc_channel

// file: rtl/ohc_top.v
// On/off hysteresis temperature regulator, four channels
// How it works
// - In reverse action the output goes off above the set point, on below.
// - The output returns only once the value is a hysteresis below set point.
// - Action selector 0 is reverse, 1 is direct, default 0.
// - Regulation selector 0 is on/off, 1 is PID, default 1.
// - Heating and cooling each have their own hysteresis.
// - Standard control type uses the heating hysteresis either way.
// - Heating hysteresis 1..9999 tenths, default 10.
// - Cooling hysteresis 1..9999 tenths, default 10.
// - Heat/cool type holds heating off in a signed dead band; cooling stays on in it down to its hysteresis below the band top.
// - Selectors apply at restart; hysteresis and dead band at once.
// - Standard type reports the heating output state per channel.
// - Heat/cool type reports heating and cooling states per channel.
`timescale 1ns/1ps
`include "ohc_consts.vh"
module ohc_top (
  input  wire        mclk,
  input  wire        reset,
  input  wire        restart,
  input  wire [63:0] pv_flat,
  input  wire [63:0] sp_flat,
  input  wire [63:0] hys_heat_flat,
  input  wire [63:0] hys_cool_flat,
  input  wire [63:0] dead_band_flat,
  input  wire [3:0]  action_sel,
  input  wire [3:0]  regulation_mode_select,
  input  wire [3:0]  heat_cool_type,
  output reg  [3:0]  heat_out,
  output reg  [3:0]  cool_out,
  output reg  [3:0]  heat_status,
  output reg  [3:0]  cool_status,
  output reg  [3:0]  onoff_active,
  output reg         tick_out
);
  localparam [15:0] PERIOD_CYC = `OHC_PERIOD_CYC;
  reg  [15:0] period_cnt_reg;
  reg         tick_reg;
  reg  [3:0]  act_reg;
  reg  [3:0]  mode_reg;
  wire [3:0]  ch_heat;
  wire [3:0]  ch_cool;
  reg         tick_d_reg;

  // Control period divider
  always @(posedge mclk) begin
    if (reset) begin
      period_cnt_reg <= 16'h0000;
      tick_reg       <= 1'b0;
    end else if (period_cnt_reg == PERIOD_CYC - 16'h0001) begin
      period_cnt_reg <= 16'h0000;
      tick_reg       <= 1'b1;
    end else begin
      period_cnt_reg <= period_cnt_reg + 16'h0001;
      tick_reg       <= 1'b0;
    end
  end

  // Selectors latch only at reset or restart, never mid-run
  always @(posedge mclk) begin
    if (reset) begin
      act_reg  <= {4{`OHC_ACT_DEF}};
      mode_reg <= {4{`OHC_MODE_DEF}};
    end else if (restart) begin
      act_reg  <= action_sel;
      mode_reg <= regulation_mode_select;
    end
  end

  genvar i;
  generate
    for (i = 0; i < `OHC_NCH; i = i + 1) begin : g_ch
      // Out-of-range hysteresis clamped; dead band clamped to its span
      wire [15:0] hh_raw = hys_heat_flat[16*i +: 16];
      wire [15:0] hc_raw = hys_cool_flat[16*i +: 16];
      wire signed [15:0] db_raw = dead_band_flat[16*i +: 16];
      wire [15:0] hh = (hh_raw < `OHC_HYS_MIN) ? `OHC_HYS_MIN :
                       (hh_raw > `OHC_HYS_MAX) ? `OHC_HYS_MAX : hh_raw;
      wire [15:0] hc = (hc_raw < `OHC_HYS_MIN) ? `OHC_HYS_MIN :
                       (hc_raw > `OHC_HYS_MAX) ? `OHC_HYS_MAX : hc_raw;
      wire signed [15:0] db_lo = `OHC_DB_MIN;
      wire signed [15:0] db_hi = `OHC_DB_MAX;
      wire signed [15:0] db = (db_raw < db_lo) ? db_lo :
                              (db_raw > db_hi) ? db_hi : db_raw;
      // Settings used live, so changes apply at the next period
      ohc_channel u_ch (
        .mclk           (mclk),
        .reset          (reset | mode_reg[i] | restart),
        .tick           (tick_reg),
        .pv             (pv_flat[16*i +: 16]),
        .sp             (sp_flat[16*i +: 16]),
        .hys_heat       (hh),
        .hys_cool       (hc),
        .dead_band      (db),
        .action_direct  (act_reg[i]),
        .heat_cool_type (heat_cool_type[i]),
        .heat_out_reg   (ch_heat[i]),
        .cool_out_reg   (ch_cool[i])
      );
    end
  endgenerate

  // Outputs and status registered together after each evaluation
  always @(posedge mclk) begin
    if (reset) begin
      heat_out     <= 4'h0;
      cool_out     <= 4'h0;
      heat_status  <= 4'h0;
      cool_status  <= 4'h0;
      onoff_active <= 4'h0;
      tick_out     <= 1'b0;
      tick_d_reg   <= 1'b0;
    end else begin
      tick_d_reg   <= tick_reg;
      tick_out     <= tick_reg;
      onoff_active <= ~mode_reg;
      if (tick_d_reg) begin
        heat_out    <= ch_heat;
        cool_out    <= ch_cool & heat_cool_type;
        heat_status <= ch_heat;
        cool_status <= ch_cool & heat_cool_type;
      end
    end
  end
endmodule // ohc_top

// file: bench/ohc_monitor.sv
// Port checker for the on/off hysteresis regulator
`timescale 1ns/1ps
module ohc_monitor (
  input wire        mclk,
  input wire        reset,
  input wire        restart,
  input wire [63:0] pv_flat,
  input wire [63:0] sp_flat,
  input wire [63:0] hys_heat_flat,
  input wire [3:0]  action_sel,
  input wire [3:0]  heat_cool_type,
  input wire [3:0]  heat_out,
  input wire [3:0]  cool_out,
  input wire [3:0]  heat_status,
  input wire [3:0]  cool_status,
  input wire [3:0]  onoff_active,
  input wire        tick_out
);
  default clocking @(posedge mclk); endclocking
  default disable iff (reset);
  // Channel 0 in reverse standard on/off; selectors held since restart
  reg                act0_reg;
  // Action as latched at restart; the live selector waits for one
  always @(posedge mclk) begin
    if (reset) begin
      act0_reg <= 1'b0;
    end else if (restart) begin
      act0_reg <= action_sel[0];
    end
  end
  wire               rev0 = onoff_active[0] & ~act0_reg
                            & ~heat_cool_type[0];
  wire signed [17:0] pv0 = $signed(pv_flat[15:0]);
  wire signed [17:0] sp0 = $signed(sp_flat[15:0]);
  wire signed [17:0] lo0 = sp0 - $signed({2'h0, hys_heat_flat[15:0]});
  // Value taken one edge before tick_out shows
  // A restart on the tick edge clears the channel instead
  sequence s_above;
    tick_out && rev0 && !$past(restart) && $past(pv0 > sp0);
  endsequence
  sequence s_below;
    tick_out && rev0 && !$past(restart) && $past(pv0 < lo0);
  endsequence
  a_heat_off_above: assert property (s_above |=> !heat_out[0])
    else $error("heating stayed on above set point");
  a_heat_on_below: assert property (s_below |=> heat_out[0])
    else $error("heating not back on below hysteresis");
  a_heat_status: assert property (heat_status == heat_out)
    else $error("heating status differs from output");
  a_cool_status: assert property (cool_status == cool_out)
    else $error("cooling status differs from output");
  a_cool_type: assert property ($rose(cool_out[0])
    |-> $past(heat_cool_type[0]))
    else $error("cooling on in standard type");
  a_pid_held: assert property (!$past(restart) && !$past(restart, 2)
    |-> (heat_out & ~onoff_active) == 4'h0)
    else $error("regulation held channel drives output");
  a_mode_latch: assert property ($changed(onoff_active)
    |-> $past(restart) || $past(restart, 2))
    else $error("mode changed without restart");
  a_out_on_tick: assert property ($changed(heat_out)
    |-> $past(tick_out) || $past(restart) || $past(restart, 2)
    || $past(restart, 3))
    else $error("output moved off the control period");
  a_tick_period: assert property (disable iff (reset || restart)
    tick_out |-> ##100 tick_out)
    else $error("control period not 100 cycles");
endmodule // ohc_monitor

// file: bench/ohc_host.sv
// Host model polling the status bits
`timescale 1ns/1ps
module ohc_host (
  input  wire       mclk,
  input  wire [3:0] heat_status,
  input  wire [3:0] cool_status,
  output reg  [7:0] snap
);
  // Poll every clock, as a cyclic host read would
  always @(posedge mclk) begin
    snap <= {cool_status, heat_status};
  end
endmodule // ohc_host

// file: bench/on_off_hysteresis_control_test.sv
// Self-checking bench for the on/off hysteresis regulator
`timescale 1ns/1ps
`include "ohc_consts.vh"
module on_off_hysteresis_control_test;
  reg        mclk = 1'h0, reset = 1'h1, restart = 1'h0;
  reg [15:0] pv = 16'h0000, sp = 16'h00c8, hh = 16'h000a, hc = 16'h0005;
  reg [15:0] db = 16'h0000;
  reg [3:0]  act = 4'h0, mode = 4'hf, hct = 4'h0;
  wire [3:0] heat_out, cool_out, heat_status, cool_status, onoff_active;
  wire       tick_out;
  wire [7:0] snap;
  integer    failures = 0, checked = 0;
  always #5 mclk = ~mclk;
  ohc_top ohc_top_i (.mclk(mclk), .reset(reset), .restart(restart),
    .pv_flat({4{pv}}), .sp_flat({4{sp}}), .hys_heat_flat({4{hh}}),
    .hys_cool_flat({4{hc}}), .dead_band_flat({4{db}}), .action_sel(act),
    .regulation_mode_select(mode), .heat_cool_type(hct),
    .heat_out(heat_out), .cool_out(cool_out), .heat_status(heat_status),
    .cool_status(cool_status), .onoff_active(onoff_active),
    .tick_out(tick_out));
  ohc_host ohc_host_i (.mclk(mclk), .heat_status(heat_status),
    .cool_status(cool_status), .snap(snap));
  task chk(input string what, input [7:0] seen, input [7:0] exp);
    begin
      #1 checked = checked + 1;
      if (seen !== exp) begin
        failures = failures + 1;
        $display("Error %0s expected %h seen %h", what, exp, seen);
      end
    end
  endtask
  // Write a measured value, let two periods pass, read back
  task run(input [15:0] p, input eh, input ec);
    begin
      @(posedge mclk) pv <= p;
      repeat (`OHC_PERIOD_CYC * 2 + 3) @(posedge mclk);
      chk("outputs", {cool_out, heat_out}, {{4{ec}}, {4{eh}}});
      chk("host", snap, {{4{ec}}, {4{eh}}});
    end
  endtask
  // Restart into on/off with the given action
  task rs(input [3:0] a);
    begin
      @(posedge mclk) act <= a;
      mode <= 4'h0;
      restart <= 1'h1;
      @(posedge mclk) restart <= 1'h0;
      repeat (3) @(posedge mclk);
      chk("mode", {4'h0, onoff_active}, 8'h0f);
    end
  endtask
  task conclude;
    begin
      $display("checked %0d failures %0d", checked, failures);
      if (failures == 0 && checked > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
    end
  endtask
  // Hang guard, several times the expected run
  initial begin
    #300000 failures = failures + 1;
    conclude;
  end
  initial begin
    repeat (5) @(posedge mclk);
    reset <= 1'h0;
    run(16'h0064, 1'h0, 1'h0);
    $display("test default mode done");
    rs(4'h0);
    run(16'h00be, 1'h0, 1'h0);
    run(16'h00bd, 1'h1, 1'h0);
    run(16'h00c8, 1'h1, 1'h0);
    run(16'h00c9, 1'h0, 1'h0);
    run(16'h00c3, 1'h0, 1'h0);
    @(posedge mclk) hh <= 16'h001e;
    run(16'h00af, 1'h0, 1'h0);
    run(16'h00a9, 1'h1, 1'h0);
    @(posedge mclk) act <= 4'hf;
    run(16'h00c9, 1'h0, 1'h0);
    $display("test reverse done");
    rs(4'hf);
    run(16'h00e6, 1'h0, 1'h0);
    run(16'h00e7, 1'h1, 1'h0);
    run(16'h00c7, 1'h0, 1'h0);
    $display("test direct done");
    @(posedge mclk) hct <= 4'hf;
    hh <= 16'h000a;
    db <= 16'h0014;
    rs(4'h0);
    run(16'h00d3, 1'h0, 1'h1);
    run(16'h00ce, 1'h0, 1'h1);
    run(16'h00cc, 1'h0, 1'h0);
    run(16'h00c3, 1'h0, 1'h0);
    run(16'h00b3, 1'h1, 1'h0);
    $display("test heat cool done");
    conclude;
  end
endmodule // on_off_hysteresis_control_test
bind ohc_top ohc_monitor ohc_monitor_i (.mclk(mclk), .reset(reset),
  .restart(restart), .pv_flat(pv_flat), .sp_flat(sp_flat),
  .hys_heat_flat(hys_heat_flat), .action_sel(action_sel),
  .heat_cool_type(heat_cool_type), .heat_out(heat_out),
  .cool_out(cool_out), .heat_status(heat_status),
  .cool_status(cool_status), .onoff_active(onoff_active),
  .tick_out(tick_out));
